// >>> logic/sleep_ctrl_pkg.sv
// Shared constants and types of the sleep and clock gating controller.
package sleep_ctrl_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_BASE_CK = 14;
  localparam int STARTUP_SHORT_CK = 6;
  localparam int STARTUP_FAST_US = 4100;
  localparam int STARTUP_SLOW_US = 65000;
  localparam int STARTUP_FAST_CYCLES = STARTUP_BASE_CK + STARTUP_FAST_US * 1000 / CLK_PERIOD_NS;
  localparam int STARTUP_SLOW_CYCLES = STARTUP_BASE_CK + STARTUP_SLOW_US * 1000 / CLK_PERIOD_NS;
  localparam int STANDBY_WAKE_CK = 6;
  localparam int HALT_EXTRA_CK = 4;
  localparam int CNT_W = 23;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] SLEEP_CONTROL_OFF = 8'h00;
  localparam logic [7:0] PERIPHERAL_CLOCK_GATE_OFF = 8'h04;
  localparam logic [7:0] PM_STATUS_OFF = 8'h08;
  localparam int ENTRY_ALLOW_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PERIPHERAL_CLOCK_GATE_RESET = 8'h00;
  localparam logic [7:0] PCG_USED_MASK = 8'h7f;
  localparam int ADC_CLOCK_STOP_BIT = 0;
  localparam int LIN_UART_CLOCK_STOP_BIT = 1;
  localparam int SPI_CLOCK_STOP_BIT = 2;
  localparam int TIMER0_CLOCK_STOP_BIT = 3;
  localparam int TIMER1_CLOCK_STOP_BIT = 4;
  localparam int POWER_STAGE_CLOCK_STOP_BIT = 5;
  localparam int CAN_CLOCK_STOP_BIT = 6;

  // ************************************************************
  // Sleep mode codes
  // ************************************************************
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC_NOISE = 3'h1;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
  localparam logic [2:0] MODE_STANDBY = 3'h6;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_ACTIVE, ST_IDLE, ST_ADC_NOISE, ST_POWER_DOWN, ST_STANDBY, ST_STARTUP, ST_HALT
  } pm_state_t;

  typedef struct packed {
    logic reset_wake;
    logic any_irq;
    logic adc_done;
    logic timer_irq;
    logic spm_ee_ready;
    logic power_stage_irq;
    logic [3:0] external_level_irqs;
  } wake_src_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic osc;
  } clk_dom_t;

  typedef struct packed {
    pm_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [7:0] sleep_control;
    logic [7:0] peripheral_clock_gate;
    logic [1:0] fuse;
    logic fuse_taken;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    clk_dom_t dom;
    logic [6:0] per_clk_en;
    logic adc_start;
    logic core_resume;
  } pm_regs_t;

endpackage

// >>> logic/sleep_and_clock_gating_ctrl.sv
// Sleep mode sequencer and peripheral clock gating with an AHB-Lite register slave.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps


module sleep_and_clock_gating_ctrl #(
  parameter int STARTUP_FAST_CYCLES = sleep_ctrl_pkg::STARTUP_FAST_CYCLES,
  parameter int STARTUP_SLOW_CYCLES = sleep_ctrl_pkg::STARTUP_SLOW_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core and system inputs.
  input wire logic sleep_instr,
  input wire logic adc_enabled,
  input wire logic crystal_clock_option,
  input wire logic [1:0] clock_source_fuses,
  input wire sleep_ctrl_pkg::wake_src_t wake_src,
  // Clock domain enables and core handshake.
  output sleep_ctrl_pkg::clk_dom_t clk_dom_en,
  output logic [6:0] per_clk_en,
  output logic adc_start,
  output logic core_resume,
  output logic sleeping
);

  // ************************************************************
  // State
  // ************************************************************
  sleep_ctrl_pkg::pm_regs_t r_reg;
  sleep_ctrl_pkg::pm_regs_t r_next;

  logic addr_phase;
  logic [2:0] mode_sel;
  logic entry_allow;
  logic adc_noise_wake;
  logic deep_wake;
  logic [sleep_ctrl_pkg::CNT_W-1:0] startup_cnt;

  assign addr_phase = hsel & htrans[1] & hready;
  assign mode_sel = r_reg.sleep_control[sleep_ctrl_pkg::MODE_LSB +: 3];
  assign entry_allow = r_reg.sleep_control[sleep_ctrl_pkg::ENTRY_ALLOW_BIT];

  // Only these events leave ADC noise reduction mode.
  assign adc_noise_wake = wake_src.adc_done | wake_src.reset_wake | wake_src.timer_irq |
    wake_src.spm_ee_ready | (|wake_src.external_level_irqs);

  // Only these events leave power-down and standby.
  assign deep_wake = wake_src.reset_wake | wake_src.power_stage_irq |
    (|wake_src.external_level_irqs);

  // ************************************************************
  // Start-up period from the clock source fuses
  // ************************************************************
  always_comb begin
    case (r_reg.fuse)
      2'h0: startup_cnt = sleep_ctrl_pkg::CNT_W'(sleep_ctrl_pkg::STARTUP_SHORT_CK - 1);
      2'h1: startup_cnt = sleep_ctrl_pkg::CNT_W'(STARTUP_FAST_CYCLES - 1);
      default: startup_cnt = sleep_ctrl_pkg::CNT_W'(STARTUP_SLOW_CYCLES - 1);
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    r_next = r_reg;
    r_next.adc_start = 1'b0;
    r_next.core_resume = 1'b0;
    r_next.hresp = 1'b0;
    r_next.hreadyout = 1'b1;

    // Fuses act like straps: taken once, on the first edge after reset release.
    if (!r_reg.fuse_taken) begin
      r_next.fuse = clock_source_fuses;
      r_next.fuse_taken = 1'b1;
    end

    // Data phase of a write lands first, so a read right behind it sees the new value.
    if (r_reg.wr_pend) begin
      case (r_reg.wr_addr)
        sleep_ctrl_pkg::SLEEP_CONTROL_OFF: begin
          r_next.sleep_control = hwdata[7:0] & 8'h0f;
        end
        sleep_ctrl_pkg::PERIPHERAL_CLOCK_GATE_OFF: begin
          r_next.peripheral_clock_gate = hwdata[7:0] & sleep_ctrl_pkg::PCG_USED_MASK;
        end
        default: begin
        end
      endcase
    end

    r_next.wr_pend = addr_phase & hwrite;
    r_next.wr_addr = {haddr[7:2], 2'b00};
    if (addr_phase && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        sleep_ctrl_pkg::SLEEP_CONTROL_OFF: begin
          r_next.hrdata = {24'h000000, r_next.sleep_control};
        end
        sleep_ctrl_pkg::PERIPHERAL_CLOCK_GATE_OFF: begin
          r_next.hrdata = {24'h000000, r_next.peripheral_clock_gate};
        end
        sleep_ctrl_pkg::PM_STATUS_OFF: begin
          r_next.hrdata = {26'h0000000, r_reg.fuse, 1'b0, r_reg.state};
        end
        default: begin
          r_next.hrdata = 32'h00000000;
        end
      endcase
    end

    // Sleep sequencer.
    case (r_reg.state)
      sleep_ctrl_pkg::ST_ACTIVE: begin
        if (sleep_instr && entry_allow) begin
          case (mode_sel)
            sleep_ctrl_pkg::MODE_IDLE: begin
              r_next.state = sleep_ctrl_pkg::ST_IDLE;
              r_next.adc_start = adc_enabled;
            end
            sleep_ctrl_pkg::MODE_ADC_NOISE: begin
              r_next.state = sleep_ctrl_pkg::ST_ADC_NOISE;
              r_next.adc_start = adc_enabled;
            end
            sleep_ctrl_pkg::MODE_POWER_DOWN: begin
              r_next.state = sleep_ctrl_pkg::ST_POWER_DOWN;
            end
            sleep_ctrl_pkg::MODE_STANDBY: begin
              // Without a crystal the oscillator cannot be trusted to idle, so no sleep.
              if (crystal_clock_option) begin
                r_next.state = sleep_ctrl_pkg::ST_STANDBY;
              end
            end
            default: begin
              r_next.state = sleep_ctrl_pkg::ST_ACTIVE;
            end
          endcase
        end
      end
      sleep_ctrl_pkg::ST_IDLE: begin
        if (wake_src.any_irq || wake_src.reset_wake) begin
          r_next.state = sleep_ctrl_pkg::ST_HALT;
          r_next.cnt = sleep_ctrl_pkg::CNT_W'(sleep_ctrl_pkg::HALT_EXTRA_CK - 1);
        end
      end
      sleep_ctrl_pkg::ST_ADC_NOISE: begin
        if (adc_noise_wake) begin
          r_next.state = sleep_ctrl_pkg::ST_HALT;
          r_next.cnt = sleep_ctrl_pkg::CNT_W'(sleep_ctrl_pkg::HALT_EXTRA_CK - 1);
        end
      end
      sleep_ctrl_pkg::ST_POWER_DOWN: begin
        if (deep_wake) begin
          r_next.state = sleep_ctrl_pkg::ST_STARTUP;
          r_next.cnt = startup_cnt;
        end
      end
      sleep_ctrl_pkg::ST_STANDBY: begin
        if (deep_wake) begin
          r_next.state = sleep_ctrl_pkg::ST_STARTUP;
          r_next.cnt = sleep_ctrl_pkg::CNT_W'(sleep_ctrl_pkg::STANDBY_WAKE_CK - 1);
        end
      end
      sleep_ctrl_pkg::ST_STARTUP: begin
        if (r_reg.cnt == '0) begin
          r_next.state = sleep_ctrl_pkg::ST_HALT;
          r_next.cnt = sleep_ctrl_pkg::CNT_W'(sleep_ctrl_pkg::HALT_EXTRA_CK - 1);
        end else begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end
      end
      sleep_ctrl_pkg::ST_HALT: begin
        if (r_reg.cnt == '0) begin
          r_next.state = sleep_ctrl_pkg::ST_ACTIVE;
          r_next.core_resume = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end
      end
      default: begin
        r_next.state = sleep_ctrl_pkg::ST_ACTIVE;
      end
    endcase

    // Clock domains follow the state being entered.
    r_next.dom = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, osc: 1'b1};
    case (r_next.state)
      sleep_ctrl_pkg::ST_IDLE: begin
        r_next.dom.cpu = 1'b0;
        r_next.dom.flash = 1'b0;
      end
      sleep_ctrl_pkg::ST_ADC_NOISE: begin
        r_next.dom.cpu = 1'b0;
        r_next.dom.flash = 1'b0;
        r_next.dom.io = 1'b0;
      end
      sleep_ctrl_pkg::ST_POWER_DOWN: begin
        r_next.dom = '0;
      end
      sleep_ctrl_pkg::ST_STANDBY, sleep_ctrl_pkg::ST_STARTUP: begin
        // Oscillator settles during start-up while the generated clocks stay off.
        r_next.dom = '0;
        r_next.dom.osc = 1'b1;
      end
      sleep_ctrl_pkg::ST_HALT: begin
        r_next.dom.cpu = 1'b0;
        r_next.dom.flash = 1'b0;
      end
      default: begin
      end
    endcase

    // Gating applies on top of the domain clocks, so active, idle and the ADC clock in ADC noise
    // mode honour it and other modes are already stopped; a freed gate restores the frozen state.
    for (int i = 0; i < 7; i++) begin
      if (i == sleep_ctrl_pkg::ADC_CLOCK_STOP_BIT) begin
        r_next.per_clk_en[i] = r_next.dom.adc & ~r_next.peripheral_clock_gate[i];
      end else begin
        r_next.per_clk_en[i] = r_next.dom.io & ~r_next.peripheral_clock_gate[i];
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg.state <= sleep_ctrl_pkg::ST_ACTIVE;
      r_reg.cnt <= '0;
      r_reg.sleep_control <= sleep_ctrl_pkg::SLEEP_CONTROL_RESET;
      r_reg.peripheral_clock_gate <= sleep_ctrl_pkg::PERIPHERAL_CLOCK_GATE_RESET;
      r_reg.fuse <= 2'h0;
      r_reg.fuse_taken <= 1'b0;
      r_reg.wr_pend <= 1'b0;
      r_reg.wr_addr <= 8'h00;
      r_reg.hrdata <= 32'h00000000;
      r_reg.hreadyout <= 1'b1;
      r_reg.hresp <= 1'b0;
      r_reg.dom <= '1;
      r_reg.per_clk_en <= 7'h7f;
      r_reg.adc_start <= 1'b0;
      r_reg.core_resume <= 1'b0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hrdata = r_reg.hrdata;
  assign hreadyout = r_reg.hreadyout;
  assign hresp = r_reg.hresp;
  assign clk_dom_en = r_reg.dom;
  assign per_clk_en = r_reg.per_clk_en;
  assign adc_start = r_reg.adc_start;
  assign core_resume = r_reg.core_resume;
  assign sleeping = ~r_reg.dom.cpu;

endmodule

// >>> test/sleep_ctrl_chk.sv
// Port checker of the sleep and clock gating controller, bound to its top module.
`timescale 1ns/1ps

// ****************************************
// Checker
// ****************************************
module sleep_ctrl_chk (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports.
  input wire logic sleep_instr,
  input wire logic adc_enabled,
  input wire sleep_ctrl_pkg::wake_src_t wake_src,
  input wire sleep_ctrl_pkg::clk_dom_t clk_dom_en,
  input wire logic [6:0] per_clk_en,
  input wire logic adc_start,
  input wire logic core_resume
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sleep_gate_a: assert property ($fell(clk_dom_en.cpu) |-> $past(sleep_instr))
    else $error("core clock stopped without a sleep instruction");
  conv_start_a: assert property (adc_start |-> $past(sleep_instr) && $past(adc_enabled)
    && !clk_dom_en.cpu && clk_dom_en.adc) else $error("conversion start outside sleep entry");
  idle_domains_a: assert property ((!clk_dom_en.cpu && clk_dom_en.io)
    |-> !clk_dom_en.flash && clk_dom_en.adc && clk_dom_en.osc) else $error("idle domains wrong");
  noise_domains_a: assert property ((clk_dom_en.adc && !clk_dom_en.io)
    |-> !clk_dom_en.cpu && !clk_dom_en.flash && clk_dom_en.osc) else $error("noise domains wrong");
  pd_all_off_a: assert property (!clk_dom_en.osc |-> clk_dom_en == 5'h00)
    else $error("clock left running with oscillator stopped");
  pd_wake_src_a: assert property ($rose(clk_dom_en.osc) |-> $past(wake_src.reset_wake
    || wake_src.power_stage_irq || |wake_src.external_level_irqs))
    else $error("oscillator restarted without a legal wake source");
  resume_halt_a: assert property (core_resume |-> clk_dom_en.cpu
    && !$past(clk_dom_en.cpu) && !$past(clk_dom_en.cpu, 4)) else $error("halt too short");
  resume_pulse_a: assert property (core_resume |=> !core_resume)
    else $error("resume pulse longer than one cycle");
  deep_gate_a: assert property (!clk_dom_en.io |-> per_clk_en[6:1] == 6'h00)
    else $error("peripheral clock running with io clock stopped");
  adc_gate_a: assert property (!clk_dom_en.adc |-> !per_clk_en[0])
    else $error("adc peripheral clock running with adc domain stopped");
endmodule

bind sleep_and_clock_gating_ctrl sleep_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .sleep_instr(sleep_instr), .adc_enabled(adc_enabled), .wake_src(wake_src),
  .clk_dom_en(clk_dom_en), .per_clk_en(per_clk_en), .adc_start(adc_start),
  .core_resume(core_resume));

// >>> test/sleep_and_clock_gating_ctrl_test.sv
// Self-checking bench of the sleep and clock gating controller.
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module sleep_and_clock_gating_ctrl_test;
  // ****************************************
  // Signals
  // ****************************************
  localparam int FAST = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sleep_instr = 1'b0;
  logic crystal = 1'b0;
  logic adc_enabled = 1'b0;
  sleep_ctrl_pkg::wake_src_t wake_src = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  sleep_ctrl_pkg::clk_dom_t clk_dom_en;
  logic [6:0] per_clk_en;
  logic adc_start;
  logic core_resume;
  logic sleeping;
  int errors = 0;
  int num_checks = 0;
  logic [2:0] codes [9] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h6, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [4:0] doms [9] = '{5'h07, 5'h03, 5'h00, 5'h01, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f};
  logic [9:0] good [4] = '{10'h100, 10'h080, 10'h001, 10'h010};
  logic [9:0] bad [4] = '{10'h000, 10'h110, 10'h1e0, 10'h1e0};
  int startup [4] = '{0, 0, FAST, sleep_ctrl_pkg::STANDBY_WAKE_CK};

  // The fast start-up count is shortened so a power-down wake stays in the run.
  sleep_and_clock_gating_ctrl #(.STARTUP_FAST_CYCLES(FAST), .STARTUP_SLOW_CYCLES(40))
    u_sleep_and_clock_gating_ctrl (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_instr(sleep_instr), .adc_enabled(adc_enabled),
    .crystal_clock_option(crystal), .clock_source_fuses(2'h1), .wake_src(wake_src),
    .clk_dom_en(clk_dom_en), .per_clk_en(per_clk_en), .adc_start(adc_start),
    .core_resume(core_resume), .sleeping(sleeping));

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic check_reg(input logic [31:0] a, input logic [31:0] ex);
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    `CHECK("register read", ex, hrdata)
    `CHECK("bus response", 1'b0, hresp)
  endtask

  // Enable words hold the mode field above the entry-allow bit.
  task automatic try_sleep(input logic [2:0] code, input logic allow);
    bus_write(32'h0, {28'h0, code, allow});
    sleep_instr <= 1'b1;
    @(posedge hclk);
    sleep_instr <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    forever #5 hclk = ~hclk;
  end

  initial begin
    repeat (4000) @(posedge hclk);
    errors++;
    $display("watchdog expired");
    finish_test;
  end

  initial begin
    int cnt;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reg(32'h0, 32'h0);
    check_reg(32'h4, 32'h0);
    check_reg(32'h8, 32'h10);
    bus_write(32'h4, 32'hff);
    check_reg(32'h4, 32'h7f);
    `CHECK("gated clocks", 7'h00, per_clk_en)
    for (int i = 0; i < 7; i++) begin
      bus_write(32'h4, 32'h1 << i);
      check_reg(32'h4, 32'h1 << i);
      `CHECK("clock enables", 7'h7f ^ (7'h1 << i), per_clk_en)
    end
    check_reg(32'hc, 32'h0);
    bus_write(32'h0, 32'hff);
    check_reg(32'h0, 32'h0f);
    $display("test registers done");
    bus_write(32'h4, 32'h4);
    try_sleep(3'h0, 1'b0);
    `CHECK("not asleep", 5'h1f, clk_dom_en)
    for (int i = 0; i < 9; i++) begin
      crystal <= (i == 3);
      adc_enabled <= (i != 1);
      try_sleep(codes[i], 1'b1);
      `CHECK("domains", doms[i], clk_dom_en)
      `CHECK("sleeping", ~doms[i][4], sleeping)
      `CHECK("peripheral clocks", {{6{doms[i][2]}}, doms[i][1]} & 7'h7b, per_clk_en)
      `CHECK("conversion start", i == 0, adc_start)
      if (i < 4) begin
        wake_src <= bad[i];
        repeat (3) @(posedge hclk);
        `CHECK("still asleep", doms[i], clk_dom_en)
        wake_src <= good[i];
        cnt = 0;
        do begin
          @(posedge hclk);
          cnt++;
        end while (core_resume !== 1'b1 && cnt < 200);
        wake_src <= '0;
        `CHECK("wake cycles", startup[i] + sleep_ctrl_pkg::HALT_EXTRA_CK + 2, cnt)
        `CHECK("domains after wake", 5'h1f, clk_dom_en)
        bus_write(32'h0, 32'h0);
      end
    end
    $display("test sleep modes done");
    finish_test;
  end
endmodule
